/* File: rtl/moisture_batch_calibration.sv */
// moisture sensor processing: offset, filter, curves, batch, 4-20 mA scale
// What this block does
// [RULE1] add signed offset to raw counts
// [RULE2] four filter settings, active one reported
// [RULE3] linear moisture to 4..20 mA mapping
// [RULE4] eight curves, each with 8-char name
// [RULE5] at most eight points per curve
// [RULE6] curves 1-4 polynomial, degree 1-4, coefficients readable
// [RULE7] curves 5-8 join points piecewise linearly
// [RULE8] active curve switchable live and reported
// [RULE9] host writes only the selected curve
// [RULE10] only enabled points form the function
// [RULE11] shift curve output by signed constant
// [RULE12] batch mode replaces continuous output, reportable
// [RULE13] compare moisture against high/low window
// [RULE14] batch starts after in-window start delay
// [RULE15] batch ends after stop delay outside
// [RULE16] exclude flow-interruption samples from average
// [RULE17] output batch average when batch ends
// [RULE18] hold average until next batch ends
// [RULE19] new batch starts automatically when conditions met
// [RULE20] report enabled, in-window, running separately
// [RULE21] clamp current at 4 and 20 mA
//
// Our own choices: the register addresses and the APB slave port.
`include "moist_regs.svh"

module moisture_batch_calibration #(
  parameter int MS_CYC = `MS_CYCLES
) (
  // clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  // apb slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  // raw sample from converter logic on mclk_i
  input  wire logic                 sample_valid_i,
  input  wire logic signed [15:0]   raw_count_i,
  // material flow present, from a pin
  input  wire logic                 flow_ok_i,
  // results
  output logic signed [15:0]        moisture_o,
  output logic                      moisture_valid_o,
  output logic [15:0]               current_ua_o
);
  import moist_pkg::*;

  // ----------------------------------------------------------------
  // registers and storage
  // ----------------------------------------------------------------
  filter_e                filt_reg;
  logic                   batch_en_reg;
  logic [2:0]             act_reg;
  logic [2:0]             edit_reg;
  logic signed [15:0]     zero_ofs_reg;
  logic signed [15:0]     ao_low_reg;
  logic signed [15:0]     ao_high_reg;
  logic signed [15:0]     win_high_reg;
  logic signed [15:0]     win_low_reg;
  logic [15:0]            start_dly_reg;
  logic [15:0]            stop_dly_reg;
  point_s                 pts [8][8];
  logic [7:0]             pen [8];
  logic [2:0]             degree [8];
  logic signed [15:0]     cshift [8];
  logic [31:0]            name_lo [8];
  logic [31:0]            name_hi [8];
  logic signed [31:0]     coef [8][5];
  logic flow_s1_reg;
  logic flow_reg;

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        in_curve;
  logic [4:0]  cw_idx;
  logic        mapped;
  logic [31:0] rd_val;
  logic [2:0]  ec;
  logic        in_win_reg;
  logic        running;
  logic signed [15:0] raw_reg;

  assign wr_en    = psel && penable && pwrite && mapped;
  assign in_curve = paddr[11:8] == 4'h1 && paddr[1:0] == 2'h0
                    && paddr[6:2] <= `CW_LAST && paddr[7] == 1'b0;
  assign cw_idx   = paddr[6:2];
  assign ec       = edit_reg;
  assign pready   = 1'b1;
  assign pslverr  = psel && penable && !mapped;

  always_comb begin
    mapped = 1'b1;
    rd_val = 32'h0;
    if (in_curve) begin
      if (cw_idx < `CW_ENABLE)
        rd_val = pts[ec][cw_idx[2:0]];
      else if (cw_idx == `CW_ENABLE)
        rd_val = {24'h0, pen[ec]};
      else if (cw_idx == `CW_DEGREE)
        rd_val = {29'h0, degree[ec]};
      else if (cw_idx == `CW_SHIFT)
        rd_val = {{16{cshift[ec][15]}}, cshift[ec]};
      else if (cw_idx == `CW_NAME_LO)
        rd_val = name_lo[ec];
      else if (cw_idx == `CW_NAME_HI)
        rd_val = name_hi[ec];
      else
        rd_val = coef[ec][3'(cw_idx - `CW_COEF0)]; // RULE6
    end else begin
      case (paddr)
        `OFS_CTRL:      rd_val = {23'h0, edit_reg, act_reg, batch_en_reg,
                                  filt_reg};
        `OFS_STATUS:    rd_val = {23'h0, flow_reg, act_reg, running,
                                  in_win_reg, batch_en_reg,
                                  filt_reg}; // RULE20 RULE2 RULE8
        `OFS_ZERO_OFS:  rd_val = {{16{zero_ofs_reg[15]}}, zero_ofs_reg};
        `OFS_AO_LOW:    rd_val = {{16{ao_low_reg[15]}}, ao_low_reg};
        `OFS_AO_HIGH:   rd_val = {{16{ao_high_reg[15]}}, ao_high_reg};
        `OFS_WIN_HIGH:  rd_val = {{16{win_high_reg[15]}}, win_high_reg};
        `OFS_WIN_LOW:   rd_val = {{16{win_low_reg[15]}}, win_low_reg};
        `OFS_START_DLY: rd_val = {16'h0, start_dly_reg};
        `OFS_STOP_DLY:  rd_val = {16'h0, stop_dly_reg};
        `OFS_RAW:       rd_val = {{16{raw_reg[15]}}, raw_reg};
        `OFS_MOIST:     rd_val = {{16{moisture_o[15]}}, moisture_o};
        `OFS_CURRENT:   rd_val = {16'h0, current_ua_o};
        default:        mapped = 1'b0;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i)
      prdata <= 32'h0;
    else if (psel && !penable)
      prdata <= rd_val;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      filt_reg      <= FILT_OFF;
      batch_en_reg  <= 1'b0;
      act_reg       <= 3'h0;
      edit_reg      <= 3'h0;
      zero_ofs_reg  <= 16'sh0;
      ao_low_reg    <= `RST_AO_LOW;
      ao_high_reg   <= `RST_AO_HIGH;
      win_high_reg  <= `RST_WIN_HIGH;
      win_low_reg   <= `RST_WIN_LOW;
      start_dly_reg <= `RST_START_DLY;
      stop_dly_reg  <= `RST_STOP_DLY;
    end else if (wr_en && !in_curve) begin
      case (paddr)
        `OFS_CTRL: begin
          filt_reg     <= filter_e'(pwdata[`CTRL_FILT_LSB +: 2]); // RULE2
          batch_en_reg <= pwdata[`CTRL_BATCH_BIT]; // RULE12
          act_reg      <= pwdata[`CTRL_ACT_LSB +: 3]; // RULE8
          edit_reg     <= pwdata[`CTRL_EDIT_LSB +: 3];
        end
        `OFS_ZERO_OFS:  zero_ofs_reg  <= pwdata[15:0];
        `OFS_AO_LOW:    ao_low_reg    <= pwdata[15:0];
        `OFS_AO_HIGH:   ao_high_reg   <= pwdata[15:0];
        `OFS_WIN_HIGH:  win_high_reg  <= pwdata[15:0];
        `OFS_WIN_LOW:   win_low_reg   <= pwdata[15:0];
        `OFS_START_DLY: start_dly_reg <= pwdata[15:0];
        `OFS_STOP_DLY:  stop_dly_reg  <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // curve storage: only the curve picked by edit_reg is written
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      for (int c = 0; c < 8; c++) begin
        for (int p = 0; p < 8; p++)
          pts[c][p] <= '0;
        for (int k = 0; k < 5; k++)
          coef[c][k] <= 32'sh0;
        pen[c]     <= 8'h0;
        degree[c]  <= `RST_DEGREE;
        cshift[c]  <= 16'sh0;
        name_lo[c] <= 32'h0;
        name_hi[c] <= 32'h0;
      end
    end else if (wr_en && in_curve) begin // RULE9
      if (cw_idx < `CW_ENABLE)
        pts[ec][cw_idx[2:0]] <= pwdata; // RULE5
      else if (cw_idx == `CW_ENABLE)
        pen[ec] <= pwdata[7:0]; // RULE10
      else if (cw_idx == `CW_DEGREE)
        degree[ec] <= (pwdata[2:0] == 3'h0) ? 3'h1 :
                      (pwdata[2:0] > 3'h4) ? 3'h4 : pwdata[2:0]; // RULE6
      else if (cw_idx == `CW_SHIFT)
        cshift[ec] <= pwdata[15:0]; // RULE11
      else if (cw_idx == `CW_NAME_LO)
        name_lo[ec] <= pwdata; // RULE4
      else if (cw_idx == `CW_NAME_HI)
        name_hi[ec] <= pwdata; // RULE4
      else
        coef[ec][3'(cw_idx - `CW_COEF0)] <= pwdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      flow_s1_reg <= 1'b0;
      flow_reg    <= 1'b0;
    end else begin
      flow_s1_reg <= flow_ok_i;
      flow_reg    <= flow_s1_reg;
    end
  end

  // ----------------------------------------------------------------
  // sample processing
  // ----------------------------------------------------------------
  proc_state_e        pstate_reg;
  logic signed [23:0] filt_acc_reg;
  logic signed [15:0] x_reg;
  logic [2:0]         curve_reg;
  logic [2:0]         k_reg;
  logic signed [31:0] acc_reg;
  logic [2:0]         lo_i_reg, hi_i_reg;
  logic               have_lo_reg, have_hi_reg;
  logic signed [15:0] m_reg;
  logic signed [23:0] x_ext, filt_diff;
  logic signed [47:0] horner;
  logic signed [33:0] interp_num;
  logic signed [16:0] interp_den;
  logic signed [33:0] interp_q;
  logic signed [15:0] curve_m;
  point_s             p_lo, p_hi, p_cur;
  logic               is_poly;

  assign x_ext     = {raw_reg, 8'h0};
  assign filt_diff = x_ext - filt_acc_reg;
  assign is_poly   = !curve_reg[2];
  assign horner    = acc_reg * x_reg;
  assign p_lo      = pts[curve_reg][lo_i_reg];
  assign p_hi      = pts[curve_reg][hi_i_reg];
  assign p_cur     = pts[curve_reg][k_reg];
  assign interp_num = 34'(x_reg - p_lo.count) * 34'(p_hi.moist - p_lo.moist);
  assign interp_den = 17'(p_hi.count) - 17'(p_lo.count);
  assign interp_q   = (interp_den > 17'sh0) ? interp_num / interp_den : 34'sh0;

  always_comb begin
    if (is_poly)
      curve_m = acc_reg[31:16];
    else if (have_lo_reg && have_hi_reg)
      curve_m = 16'(p_lo.moist + interp_q[15:0]); // RULE7
    else if (have_lo_reg)
      curve_m = p_lo.moist;
    else if (have_hi_reg)
      curve_m = p_hi.moist;
    else
      curve_m = 16'sh0;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pstate_reg   <= P_IDLE;
      raw_reg      <= 16'sh0;
      filt_acc_reg <= 24'sh0;
      x_reg        <= 16'sh0;
      curve_reg    <= 3'h0;
      k_reg        <= 3'h0;
      acc_reg      <= 32'sh0;
      lo_i_reg     <= 3'h0;
      hi_i_reg     <= 3'h0;
      have_lo_reg  <= 1'b0;
      have_hi_reg  <= 1'b0;
      m_reg        <= 16'sh0;
    end else begin
      case (pstate_reg)
        P_IDLE: if (sample_valid_i) begin
          raw_reg    <= 16'(raw_count_i + zero_ofs_reg); // RULE1
          pstate_reg <= P_FILT;
        end
        P_FILT: begin
          if (filt_reg == FILT_OFF)
            filt_acc_reg <= x_ext;
          else
            filt_acc_reg <= filt_acc_reg +
                            (filt_diff >>> {filt_reg, 1'b0}); // RULE2
          x_reg       <= (filt_reg == FILT_OFF) ? raw_reg :
                         16'((filt_acc_reg +
                              (filt_diff >>> {filt_reg, 1'b0})) >>> 8);
          curve_reg   <= act_reg; // RULE8
          k_reg       <= act_reg[2] ? 3'h0 : degree[act_reg];
          acc_reg     <= coef[act_reg][degree[act_reg]];
          have_lo_reg <= 1'b0;
          have_hi_reg <= 1'b0;
          pstate_reg  <= P_CALC;
        end
        P_CALC: begin
          if (is_poly) begin
            if (k_reg == 3'h0)
              pstate_reg <= P_DIV;
            else begin
              acc_reg <= horner[31:0] + coef[curve_reg][k_reg - 3'h1]; // RULE6
              k_reg   <= k_reg - 3'h1;
            end
          end else begin
            if (pen[curve_reg][k_reg]) begin // RULE10
              if (p_cur.count <= x_reg) begin
                lo_i_reg    <= k_reg;
                have_lo_reg <= 1'b1;
              end else if (!have_hi_reg) begin
                hi_i_reg    <= k_reg;
                have_hi_reg <= 1'b1;
              end
            end
            k_reg <= k_reg + 3'h1;
            if (k_reg == 3'h7)
              pstate_reg <= P_DIV;
          end
        end
        P_DIV: begin
          m_reg      <= 16'(curve_m + cshift[curve_reg]); // RULE11
          pstate_reg <= P_OUT;
        end
        P_OUT:   pstate_reg <= P_IDLE;
        default: pstate_reg <= P_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // batch averaging
  // ----------------------------------------------------------------
  batch_state_e       bstate_reg;
  logic [15:0]        tick_reg;
  logic               ms_tick;
  logic [15:0]        in_ms_reg, out_ms_reg;
  logic signed [39:0] sum_reg;
  logic [23:0]        n_reg;
  logic signed [15:0] held_reg;
  logic signed [39:0] avg;
  logic               sample_done;
  logic               in_win_now;

  assign ms_tick     = tick_reg == 16'(MS_CYC - 1);
  assign sample_done = pstate_reg == P_OUT;
  assign in_win_now  = m_reg >= win_low_reg && m_reg <= win_high_reg;
  assign running     = bstate_reg == B_RUN;
  assign avg         = (n_reg == 24'h0) ? 40'sh0 :
                       sum_reg / $signed({1'b0, n_reg});

  always_ff @(posedge mclk_i) begin
    if (reset_i)
      tick_reg <= 16'h0;
    else
      tick_reg <= ms_tick ? 16'h0 : tick_reg + 16'h1;
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i)
      in_win_reg <= 1'b0;
    else if (sample_done)
      in_win_reg <= in_win_now; // RULE13
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i || !batch_en_reg) begin
      bstate_reg <= B_WAIT;
      in_ms_reg  <= 16'h0;
      out_ms_reg <= 16'h0;
      sum_reg    <= 40'sh0;
      n_reg      <= 24'h0;
    end else begin
      case (bstate_reg)
        B_WAIT: begin
          if (!in_win_reg)
            in_ms_reg <= 16'h0;
          else if (in_ms_reg >= start_dly_reg) begin // RULE14 RULE19
            bstate_reg <= B_RUN;
            out_ms_reg <= 16'h0;
            sum_reg    <= 40'sh0;
            n_reg      <= 24'h0;
          end else if (ms_tick && flow_reg)
            in_ms_reg <= in_ms_reg + 16'h1; // RULE14
        end
        B_RUN: begin
          if (sample_done && flow_reg) begin // RULE16
            sum_reg <= sum_reg + 40'(m_reg);
            n_reg   <= n_reg + 24'h1;
          end
          if (in_win_reg)
            out_ms_reg <= 16'h0; // RULE15
          else if (out_ms_reg >= stop_dly_reg) begin
            bstate_reg <= B_WAIT; // RULE15
            in_ms_reg  <= 16'h0;
          end else if (ms_tick)
            out_ms_reg <= out_ms_reg + 16'h1;
        end
        default: bstate_reg <= B_WAIT;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i)
      held_reg <= 16'sh0;
    else if (running && !in_win_reg && out_ms_reg >= stop_dly_reg)
      held_reg <= avg[15:0]; // RULE17
  end

  // ----------------------------------------------------------------
  // result and current loop
  // ----------------------------------------------------------------
  logic signed [15:0] out_m;
  logic signed [16:0] span;
  logic signed [33:0] cur_num;
  logic signed [33:0] cur_q;
  logic [15:0]        cur_ua;

  always_comb begin
    if (!batch_en_reg)
      out_m = m_reg; // RULE12
    else if (running)
      out_m = held_reg; // RULE18
    else
      out_m = held_reg; // RULE17
  end

  assign span    = 17'(ao_high_reg) - 17'(ao_low_reg);
  assign cur_num = 34'(out_m - ao_low_reg) * 34'sd16000;
  assign cur_q   = (span > 17'sh0) ? cur_num / span : 34'sh0;

  always_comb begin
    if (span <= 17'sh0 || out_m <= ao_low_reg)
      cur_ua = `CUR_MIN_UA; // RULE21
    else if (out_m >= ao_high_reg)
      cur_ua = `CUR_MAX_UA; // RULE21
    else
      cur_ua = 16'(`CUR_MIN_UA + cur_q[15:0]); // RULE3
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      moisture_o       <= 16'sh0;
      moisture_valid_o <= 1'b0;
      current_ua_o     <= `CUR_MIN_UA;
    end else begin
      moisture_valid_o <= sample_done;
      if (sample_done) begin
        moisture_o   <= out_m;
        current_ua_o <= cur_ua;
      end
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  a_cur_range: assert property (current_ua_o >= `CUR_MIN_UA && // RULE21
    current_ua_o <= `CUR_MAX_UA) else $error("current out of 4-20 mA");
  a_cur_low_clamp: assert property (sample_done && out_m <= ao_low_reg // RULE21
    |=> current_ua_o == `CUR_MIN_UA) else $error("low end not 4 mA");
  a_offset_add: assert property (pstate_reg == P_IDLE && sample_valid_i // RULE1
    |=> raw_reg == 16'($past(raw_count_i) + $past(zero_ofs_reg)))
    else $error("offset not applied");
  a_curve_kind: assert property (pstate_reg == P_FILT // RULE8
    |=> curve_reg == $past(act_reg) && is_poly == !$past(act_reg[2]))
    else $error("curve not taken from active");
  a_proc_latency: assert property (pstate_reg == P_IDLE && sample_valid_i // RULE6
    |-> ##[4:12] moisture_valid_o) else $error("sample not finished");
  a_batch_start: assert property ($rose(running) // RULE14
    |-> $past(in_ms_reg) >= $past(start_dly_reg) && $past(in_win_reg))
    else $error("batch started early");
  a_batch_stop: assert property (batch_en_reg && $fell(running) // RULE15
    |-> $past(out_ms_reg) >= $past(stop_dly_reg))
    else $error("batch stopped early");
  a_flow_exclude: assert property (running && sample_done && !flow_reg // RULE16
    |=> $stable(n_reg)) else $error("interrupted sample counted");
  a_batch_hold: assert property (batch_en_reg && moisture_valid_o // RULE18
    |-> moisture_o == $past(held_reg)) else $error("batch output not held");
  a_cont_out: assert property (!batch_en_reg && sample_done // RULE12
    |=> moisture_o == $past(m_reg)) else $error("continuous output wrong");

  c_batch_run: cover property ($rose(running));
  c_batch_end: cover property (batch_en_reg && $fell(running));
  c_poly_done: cover property (sample_done && is_poly);
  c_list_done: cover property (sample_done && !is_poly && have_hi_reg);

endmodule

/* File: include/moist_regs.svh */
// register offsets, field positions, reset values and timing constants
`ifndef MOIST_REGS_SVH
`define MOIST_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL        12'h000
`define OFS_STATUS      12'h004
`define OFS_ZERO_OFS    12'h008
`define OFS_AO_LOW      12'h00c
`define OFS_AO_HIGH     12'h010
`define OFS_WIN_HIGH    12'h014
`define OFS_WIN_LOW     12'h018
`define OFS_START_DLY   12'h01c
`define OFS_STOP_DLY    12'h020
`define OFS_RAW         12'h024
`define OFS_MOIST       12'h028
`define OFS_CURRENT     12'h02c
// curve edit window, word index inside it
`define OFS_CURVE_BASE  12'h100
`define CW_POINT0       5'h00
`define CW_ENABLE       5'h08
`define CW_DEGREE       5'h09
`define CW_SHIFT        5'h0a
`define CW_NAME_LO      5'h0b
`define CW_NAME_HI      5'h0c
`define CW_COEF0        5'h0d
`define CW_LAST         5'h11

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define CTRL_FILT_LSB   0
`define CTRL_BATCH_BIT  2
`define CTRL_ACT_LSB    3
`define CTRL_EDIT_LSB   6
`define ST_FILT_LSB     0
`define ST_BATCH_BIT    2
`define ST_INWIN_BIT    3
`define ST_RUN_BIT      4
`define ST_ACT_LSB      5
`define ST_FLOW_BIT     8

// ----------------------------------------------------------------
// reset values (moisture in 0.01 % steps, delays in ms)
// ----------------------------------------------------------------
`define RST_AO_LOW      16'sh0000
`define RST_AO_HIGH     16'sh2710
`define RST_WIN_HIGH    16'sh0640
`define RST_WIN_LOW     16'sh0190
`define RST_START_DLY   16'h07d0
`define RST_STOP_DLY    16'h07d0
`define RST_DEGREE      3'h1

// ----------------------------------------------------------------
// timing and output scaling
// ----------------------------------------------------------------
`define CLK_PERIOD_NS   20
`define MS_NS           1000000
`define MS_CYCLES       (`MS_NS / `CLK_PERIOD_NS)
`define CUR_MIN_UA      16'd4000
`define CUR_MAX_UA      16'd20000

`endif

/* File: include/moist_pkg.sv */
// types shared by the moisture processing block
package moist_pkg;

  typedef enum logic [1:0] {
    FILT_OFF    = 2'h0,
    FILT_WEAK   = 2'h1,
    FILT_MEDIUM = 2'h2,
    FILT_STRONG = 2'h3
  } filter_e;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_FILT = 3'b001,
    P_CALC = 3'b011,
    P_DIV  = 3'b010,
    P_OUT  = 3'b110
  } proc_state_e;

  typedef enum logic {
    B_WAIT = 1'b0,
    B_RUN  = 1'b1
  } batch_state_e;

  typedef struct packed {
    logic signed [15:0] moist;
    logic signed [15:0] count;
  } point_s;

endpackage

/* File: verif/moist_host.sv */
// apb host model: configuration software side of the block
module moist_host (
  // clock
  input  wire logic        mclk_i,
  // apb master
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end
  // one transfer, entered just after a rising edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
            output logic [31:0] r, output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do @(posedge mclk_i); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk_i);
  endtask
endmodule

/* File: verif/moisture_batch_calibration_tb_top.sv */
// self-checking bench for the moisture processing block
`include "moist_regs.svh"
module moisture_batch_calibration_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_i = 0, reset_i = 1, sample_valid_i = 0, flow_ok_i = 1;
  logic signed [15:0] raw_count_i = 16'sh0000, moisture_o;
  logic psel, penable, pwrite, pready, pslverr, moisture_valid_o;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] current_ua_o;
  logic e;
  int mismatches = 0, num_checks = 0, cyc = 0, i;
  logic [11:0] ra[9] = '{`OFS_CTRL, `OFS_AO_LOW, `OFS_AO_HIGH,
    `OFS_WIN_HIGH, `OFS_WIN_LOW, `OFS_START_DLY, `OFS_STOP_DLY,
    `OFS_CURRENT, 12'h124};
  logic [31:0] rv[9] = '{32'h0, 32'h0, 32'h2710, 32'h640, 32'h190,
    32'h7d0, 32'h7d0, 32'hfa0, 32'h1};
  moist_host host (.*);
  moisture_batch_calibration #(.MS_CYC(4)) dut (.*);
  initial forever #10 mclk_i = ~mclk_i;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task chk(input string n, input logic [31:0] got, input logic [31:0] x);
    num_checks++;
    if (got !== x) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", n, x, got);
    end
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, r, e);
  endtask
  task rd(input logic [11:0] a);
    host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task smp(input logic signed [15:0] c);
    sample_valid_i <= 1'b1;
    raw_count_i <= c;
    @(posedge mclk_i);
    sample_valid_i <= 1'b0;
    for (i = 0; i < 40 && moisture_valid_o !== 1'b1; i++) @(posedge mclk_i);
    chk("valid", moisture_valid_o, 1'b1);
    repeat (8) @(posedge mclk_i);
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      close_out;
    end
  end
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    chk("current", current_ua_o, 32'd4000);
    for (int k = 0; k < 9; k++) begin
      rd(ra[k]);
      chk("reset", r, rv[k]);
    end
    rd(12'hffc);
    chk("err", e, 1'b1);
    rd(12'h102);
    chk("err", e, 1'b1);
    $display("test regs done");
    wr(`OFS_ZERO_OFS, 32'hfffffffb);
    smp(105);
    rd(`OFS_RAW);
    chk("raw", r, 32'h64);
    wr(`OFS_ZERO_OFS, 32'h0);
    wr(12'h12c, 32'h646e6153);
    rd(12'h12c);
    chk("name", r, 32'h646e6153);
    wr(12'h124, 32'h7);
    rd(12'h124);
    chk("degree", r, 32'h4);
    wr(12'h138, 32'h10000);
    smp(100);
    chk("poly", moisture_o, 32'h64);
    chk("cur", current_ua_o, 32'd4160);
    rd(12'h138);
    chk("coef", r, 32'h10000);
    wr(12'h128, 32'd50);
    smp(100);
    chk("shift", moisture_o, 32'd150);
    smp(20000);
    chk("clamp", current_ua_o, 32'd20000);
    smp(-200);
    chk("clamp", current_ua_o, 32'd4000);
    // medium filter: y moves (x-y)/16 from -200 towards 1400
    wr(`OFS_CTRL, 32'h2);
    smp(1400);
    chk("filt", moisture_o, 32'hffffffce);
    $display("test poly done");
    wr(`OFS_CTRL, 32'h120);
    wr(12'h104, 32'h03e80064);
    wr(12'h108, 32'h138800c8);
    wr(12'h120, 32'h3);
    smp(50);
    chk("list", moisture_o, 32'd500);
    smp(150);
    chk("mask", moisture_o, 32'd1000);
    wr(`OFS_CTRL, 32'h122);
    rd(`OFS_STATUS);
    chk("stat", {r[7:5], r[1:0]}, 32'h12);
    wr(`OFS_CTRL, 32'h0);
    rd(12'h104);
    chk("other", r, 32'h0);
    wr(12'h128, 32'h0);
    $display("test list done");
    wr(`OFS_START_DLY, 32'h1);
    wr(`OFS_STOP_DLY, 32'ha);
    wr(`OFS_CTRL, 32'h4);
    repeat (4) smp(500);
    chk("hold", moisture_o, 32'h0);
    rd(`OFS_STATUS);
    chk("run", r[4:2], 32'h7);
    flow_ok_i <= 1'b0;
    repeat (3) @(posedge mclk_i);
    smp(700);
    smp(3000);
    rd(`OFS_STATUS);
    chk("short", r[4], 1'b1);
    repeat (4) smp(3000);
    rd(`OFS_STATUS);
    chk("end", r[4], 1'b0);
    chk("avg", moisture_o, 32'd500);
    flow_ok_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    repeat (3) smp(800);
    rd(`OFS_STATUS);
    chk("again", r[4], 1'b1);
    chk("kept", moisture_o, 32'd500);
    wr(`OFS_CTRL, 32'h0);
    smp(100);
    chk("cont", moisture_o, 32'd100);
    $display("test batch done");
    reset_i <= 1'b1;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    chk("rst_m", moisture_o, 32'h0);
    chk("rst_cur", current_ua_o, 32'd4000);
    rd(`OFS_CTRL);
    chk("rst_ctrl", r, 32'h0);
    $display("test reset done");
    close_out;
  end
endmodule
